// ### rtl/ccc_pkg.sv
// Constants for the control channel configuration registers
package ccc_pkg;
  localparam logic [7:0] CCC_OFS_GEN_CFG1 = 8'h03;
  localparam logic [7:0] CCC_OFS_WDOG = 8'h04;
  localparam logic [7:0] CCC_OFS_SER_CTL1 = 8'h05;
  localparam logic [7:0] CCC_RST_GEN_CFG1 = 8'hF0;
  localparam logic [7:0] CCC_RST_WDOG = 8'hFE;
  localparam logic [7:0] CCC_RST_SER_CTL1 = 8'h1E;
  // Writable bits of general config one; others are reserved
  localparam logic [7:0] CCC_WMASK_GEN_CFG1 = 8'h7C;
  localparam int CCC_BIT_CRC_EN = 6;
  localparam int CCC_BIT_PULL_DOWN = 5;
  localparam int CCC_BIT_FILT_EN = 4;
  localparam int CCC_BIT_PASS_THRU = 3;
  localparam int CCC_BIT_AUTO_ACK = 2;
  localparam int CCC_BIT_WDOG_DIS = 0;
  localparam int CCC_BIT_PASS_ALL = 7;
  localparam int CCC_HOLD_LSB = 4;
  localparam int CCC_HOLD_MSB = 6;
  localparam int CCC_FILT_LSB = 0;
  localparam int CCC_FILT_MSB = 3;
  localparam int CCC_WDOG_LSB = 1;
  localparam int CCC_WDOG_MSB = 7;
  // Clock and time units
  localparam int CCC_CLK_NS = 100;
  localparam int CCC_WDOG_STEP_MS = 2;
  localparam int CCC_WDOG_STEP_CYC = CCC_WDOG_STEP_MS * 1000000 / CCC_CLK_NS;
  localparam int CCC_HOLD_STEP_NS = 50;
  localparam int CCC_GLITCH_STEP_NS = 5;
  localparam int CCC_PIX_MIN_CYC = 2;
endpackage

// ### rtl/ccc_sync.sv
// Three-stage input synchroniser with agreement check
`timescale 1ns/100ps
`default_nettype none
module ccc_sync (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic d,
  output logic q
);
  logic s1_q, s2_q, s3_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      // Idle level of the sync pins is low, so no false edge follows reset
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/ccc_regs.sv
// Control channel configuration registers and their controlled logic
`timescale 1ns/100ps
`default_nettype none
module ccc_regs
  import ccc_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic DATA_ENABLE_INPUT,
  input wire logic HORIZONTAL_SYNC_INPUT,
  input wire logic VERTICAL_SYNC_INPUT,
  output logic DATA_ENABLE_OUT,
  output logic HORIZONTAL_SYNC_OUT,
  output logic VERTICAL_SYNC_OUT,
  input wire logic XACT_START,
  input wire logic XACT_DONE,
  input wire logic [6:0] XACT_ADDR,
  input wire logic ALIAS_HIT,
  input wire logic [6:0] ALIAS_PHYS_ADDR,
  input wire logic FWD_LOCKED,
  output logic FWD_EN,
  output logic [6:0] FWD_ADDR,
  output logic XACT_ACK,
  output logic WDOG_ABORT,
  output logic CRC_GEN_EN,
  output logic PULL_DOWN_SEL,
  output logic [2:0] SDA_HOLD_STEPS,
  output logic [3:0] GLITCH_STEPS
);
  logic [7:0] gen_cfg1_q, wdog_q, ser_ctl1_q;
  logic [2:0] raw_in, sync_in;
  logic [2:0] prev_q, out_q;
  logic [1:0] stable_cnt_q [3];
  logic busy_q;
  logic [$clog2(CCC_WDOG_STEP_CYC)-1:0] step_cnt_q;
  logic [6:0] step_num_q;
  logic wdog_run;

  // Reserved bits keep reset value; writes only touch writable bits
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gen_cfg1_q <= CCC_RST_GEN_CFG1;
      wdog_q <= CCC_RST_WDOG;
      ser_ctl1_q <= CCC_RST_SER_CTL1;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        CCC_OFS_GEN_CFG1: gen_cfg1_q <= (REG_WDATA & CCC_WMASK_GEN_CFG1) |
                                        (CCC_RST_GEN_CFG1 & ~CCC_WMASK_GEN_CFG1);
        CCC_OFS_WDOG: wdog_q <= REG_WDATA;
        CCC_OFS_SER_CTL1: ser_ctl1_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        CCC_OFS_GEN_CFG1: REG_RDATA <= gen_cfg1_q;
        CCC_OFS_WDOG: REG_RDATA <= wdog_q;
        CCC_OFS_SER_CTL1: REG_RDATA <= ser_ctl1_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CRC_GEN_EN <= CCC_RST_GEN_CFG1[CCC_BIT_CRC_EN];
      PULL_DOWN_SEL <= CCC_RST_GEN_CFG1[CCC_BIT_PULL_DOWN];
      SDA_HOLD_STEPS <= CCC_RST_SER_CTL1[CCC_HOLD_MSB:CCC_HOLD_LSB];
      GLITCH_STEPS <= CCC_RST_SER_CTL1[CCC_FILT_MSB:CCC_FILT_LSB];
    end else begin
      CRC_GEN_EN <= gen_cfg1_q[CCC_BIT_CRC_EN];
      PULL_DOWN_SEL <= gen_cfg1_q[CCC_BIT_PULL_DOWN];
      SDA_HOLD_STEPS <= ser_ctl1_q[CCC_HOLD_MSB:CCC_HOLD_LSB];
      GLITCH_STEPS <= ser_ctl1_q[CCC_FILT_MSB:CCC_FILT_LSB];
    end
  end

  assign raw_in = {VERTICAL_SYNC_INPUT, HORIZONTAL_SYNC_INPUT, DATA_ENABLE_INPUT};

  // Pulse filter: a new level passes only after it held two clocks
  for (genvar i = 0; i < 3; i++) begin : g_filt
    ccc_sync u_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .d(raw_in[i]),
      .q(sync_in[i])
    );
    always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
        prev_q[i] <= 1'b0;
        stable_cnt_q[i] <= 2'h0;
        out_q[i] <= 1'b0;
      end else begin
        prev_q[i] <= sync_in[i];
        if (sync_in[i] != prev_q[i]) begin
          stable_cnt_q[i] <= 2'h1;
        end else if (stable_cnt_q[i] < 2'(CCC_PIX_MIN_CYC)) begin
          stable_cnt_q[i] <= stable_cnt_q[i] + 2'h1;
        end
        if (!gen_cfg1_q[CCC_BIT_FILT_EN]) begin
          out_q[i] <= sync_in[i];
        end else if (sync_in[i] == prev_q[i] && stable_cnt_q[i] >= 2'(CCC_PIX_MIN_CYC - 1)) begin
          out_q[i] <= sync_in[i];
        end
      end
    end
  end
  assign DATA_ENABLE_OUT = out_q[0];
  assign HORIZONTAL_SYNC_OUT = out_q[1];
  assign VERTICAL_SYNC_OUT = out_q[2];

  // Forwarding decision and address remap
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      FWD_EN <= 1'b0;
      FWD_ADDR <= 7'h00;
      XACT_ACK <= 1'b0;
    end else if (XACT_START) begin
      if (ser_ctl1_q[CCC_BIT_PASS_ALL]) begin
        FWD_EN <= 1'b1;
        FWD_ADDR <= XACT_ADDR;
      end else if (gen_cfg1_q[CCC_BIT_PASS_THRU] && ALIAS_HIT) begin
        FWD_EN <= 1'b1;
        FWD_ADDR <= ALIAS_PHYS_ADDR;
      end else begin
        FWD_EN <= 1'b0;
        FWD_ADDR <= XACT_ADDR;
      end
      XACT_ACK <= FWD_LOCKED | gen_cfg1_q[CCC_BIT_AUTO_ACK];
    end
  end

  // Watchdog; a zero field aborts at once, so hosts avoid it
  assign wdog_run = busy_q && !wdog_q[CCC_BIT_WDOG_DIS];
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_q <= 1'b0;
      step_cnt_q <= '0;
      step_num_q <= 7'h00;
      WDOG_ABORT <= 1'b0;
    end else begin
      WDOG_ABORT <= 1'b0;
      if (XACT_START) begin
        busy_q <= 1'b1;
        step_cnt_q <= '0;
        step_num_q <= 7'h00;
      end else if (XACT_DONE) begin
        busy_q <= 1'b0;
      end else if (wdog_run) begin
        if (step_num_q >= wdog_q[CCC_WDOG_MSB:CCC_WDOG_LSB]) begin
          WDOG_ABORT <= 1'b1;
          busy_q <= 1'b0;
        end else if (step_cnt_q == ($bits(step_cnt_q))'(CCC_WDOG_STEP_CYC - 1)) begin
          step_cnt_q <= '0;
          step_num_q <= step_num_q + 7'h01;
        end else begin
          step_cnt_q <= step_cnt_q + 1'b1;
        end
      end
    end
  end

  reset_vals_a: assert property (@(posedge CLK) $rose(ARST_N) |->
    gen_cfg1_q == CCC_RST_GEN_CFG1 && wdog_q == CCC_RST_WDOG && ser_ctl1_q == CCC_RST_SER_CTL1)
    else $error("register reset value wrong");
  reserved_bits_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    (gen_cfg1_q & ~CCC_WMASK_GEN_CFG1) == (CCC_RST_GEN_CFG1 & ~CCC_WMASK_GEN_CFG1))
    else $error("reserved bit changed");
  crc_follow_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ##1 CRC_GEN_EN == $past(gen_cfg1_q[CCC_BIT_CRC_EN]))
    else $error("crc enable mismatch");
  pull_follow_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ##1 PULL_DOWN_SEL == $past(gen_cfg1_q[CCC_BIT_PULL_DOWN]))
    else $error("pull select mismatch");
  filter_short_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    $past(gen_cfg1_q[CCC_BIT_FILT_EN]) && $changed(out_q[0])
    |-> $past(sync_in[0]) == out_q[0] && $past(sync_in[0], 2) == out_q[0])
    else $error("short pulse passed");
  pass_alias_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    XACT_START && !ser_ctl1_q[CCC_BIT_PASS_ALL] && gen_cfg1_q[CCC_BIT_PASS_THRU] && ALIAS_HIT
    |=> FWD_EN && FWD_ADDR == $past(ALIAS_PHYS_ADDR))
    else $error("alias not forwarded");
  pass_all_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    XACT_START && ser_ctl1_q[CCC_BIT_PASS_ALL] |=> FWD_EN)
    else $error("pass all failed");
  auto_ack_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    XACT_START && gen_cfg1_q[CCC_BIT_AUTO_ACK] |=> XACT_ACK)
    else $error("auto ack missing");
  wdog_off_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    wdog_q[CCC_BIT_WDOG_DIS] |=> !WDOG_ABORT)
    else $error("disabled watchdog fired");
  hold_follow_a: assert property (@(posedge CLK) disable iff (!ARST_N)
    ##1 SDA_HOLD_STEPS == $past(ser_ctl1_q[CCC_HOLD_MSB:CCC_HOLD_LSB])
    && GLITCH_STEPS == $past(ser_ctl1_q[CCC_FILT_MSB:CCC_FILT_LSB]))
    else $error("serial control outputs mismatch");
endmodule
`default_nettype wire

// ### test/ccc_xact_model.sv
// Transaction source standing in for local host and remote side
`timescale 1ns/100ps
`default_nettype none
module ccc_xact_model (
  input wire logic clk,
  output logic start,
  output logic done,
  output logic [6:0] addr,
  output logic hit,
  output logic [6:0] phys
);
  initial begin
    {start, done, addr, hit, phys} = '0;
  end
  // Released qualifiers invert so stale values never look valid
  task automatic xact(input logic [6:0] a, input logic h, input logic [6:0] p);
    @(negedge clk);
    {start, addr, hit, phys} = {1'b1, a, h, p};
    @(negedge clk);
    {start, addr, hit, phys} = {1'b0, ~a, ~h, ~p};
  endtask
  task automatic close();
    @(negedge clk);
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/tb_ccc_regs.sv
// Self-checking bench for the control channel configuration registers
`timescale 1ns/100ps
`default_nettype none
module tb_ccc_regs;
  import ccc_pkg::*;
  typedef struct {logic [7:0] a, w, r;} ccc_row_s;
  logic CLK, ARST_N, REG_WR, REG_RD, en_pin, hsync_pin, vsync_pin, LOCK, en_out, hsync_out, vsync_out;
  logic fwd_en, ack, abort, crc, pull;
  logic start, done, hit;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] xaddr, phys, fwd_addr;
  logic [2:0] hold;
  logic [3:0] glitch;
  int miscompares = 0, samples_checked = 0, n;
  ccc_row_s rows [5] = '{'{8'h03, 8'hFF, 8'hFC}, '{8'h03, 8'h00, 8'h80}, '{8'h05, 8'h25, 8'h25},
    '{8'h04, 8'h03, 8'h03}, '{8'h07, 8'hFF, 8'h00}};
  ccc_regs ccc_regs_inst (.CLK(CLK), .ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .DATA_ENABLE_INPUT(en_pin), .HORIZONTAL_SYNC_INPUT(hsync_pin),
    .VERTICAL_SYNC_INPUT(vsync_pin), .DATA_ENABLE_OUT(en_out), .HORIZONTAL_SYNC_OUT(hsync_out),
    .VERTICAL_SYNC_OUT(vsync_out),
    .XACT_START(start), .XACT_DONE(done), .XACT_ADDR(xaddr), .ALIAS_HIT(hit), .ALIAS_PHYS_ADDR(phys),
    .FWD_LOCKED(LOCK), .FWD_EN(fwd_en), .FWD_ADDR(fwd_addr), .XACT_ACK(ack), .WDOG_ABORT(abort),
    .CRC_GEN_EN(crc), .PULL_DOWN_SEL(pull), .SDA_HOLD_STEPS(hold), .GLITCH_STEPS(glitch));
  ccc_xact_model ccc_xact_model_inst (.clk(CLK), .start(start), .done(done), .addr(xaddr), .hit(hit),
    .phys(phys));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    {REG_WR, addr, wdata} = {1'b1, a, d};
    @(negedge CLK);
    REG_WR = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge CLK);
    {REG_RD, addr} = {1'b1, a};
    @(negedge CLK);
    REG_RD = 1'b0;
    chk("rdata", e, rdata);
  endtask
  // Address is only meaningful when forwarding
  task automatic tx(input logic h, input logic [6:0] ea, input logic [1:0] e);
    ccc_xact_model_inst.xact(7'h2A, h, 7'h51);
    chk("en_ack", {6'h0, e}, {6'h0, fwd_en, ack});
    if (e[1]) chk("fwd_addr", {1'b0, ea}, {1'b0, fwd_addr});
    ccc_xact_model_inst.close();
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #8000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    {ARST_N, REG_WR, REG_RD, addr, wdata, en_pin, hsync_pin, vsync_pin, LOCK} = '0;
    repeat (16) @(negedge CLK);
    ARST_N = 1'b1;
    rd(CCC_OFS_GEN_CFG1, CCC_RST_GEN_CFG1);
    rd(CCC_OFS_WDOG, CCC_RST_WDOG);
    rd(CCC_OFS_SER_CTL1, CCC_RST_SER_CTL1);
    chk("crc_pull", 8'h03, {6'h0, crc, pull});
    chk("hold_glitch", 8'h1E, {1'b0, hold, glitch});
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    chk("crc_pull", 8'h00, {6'h0, crc, pull});
    chk("hold_glitch", 8'h25, {1'b0, hold, glitch});
    tx(1'b1, 7'h00, 2'b00);
    LOCK = 1'b1;
    tx(1'b1, 7'h00, 2'b01);
    LOCK = 1'b0;
    wr(CCC_OFS_GEN_CFG1, 8'hF8);
    tx(1'b1, 7'h51, 2'b10);
    tx(1'b0, 7'h00, 2'b00);
    wr(CCC_OFS_GEN_CFG1, 8'hF4);
    tx(1'b0, 7'h00, 2'b01);
    wr(CCC_OFS_SER_CTL1, 8'h9E);
    tx(1'b0, 7'h2A, 2'b11);
    @(negedge CLK) en_pin = 1'b1;
    @(negedge CLK) en_pin = 1'b0;
    n = 0;
    repeat (10) @(negedge CLK) n += en_out;
    chk("short_pulse", 8'h00, n[7:0]);
    // Exactly two clocks is the shortest pulse that must survive
    repeat (2) @(negedge CLK) en_pin = 1'b1;
    @(negedge CLK) en_pin = 1'b0;
    n = 0;
    repeat (12) @(negedge CLK) n += en_out;
    chk("two_clk_pulse", 8'h02, n[7:0]);
    {en_pin, hsync_pin, vsync_pin} = 3'b111;
    repeat (8) @(negedge CLK);
    chk("long_pulse", 8'h07, {5'h0, en_out, hsync_out, vsync_out});
    {en_pin, hsync_pin, vsync_pin} = 3'b000;
    // Disabled watchdog with a one-step timeout must stay quiet
    ccc_xact_model_inst.xact(7'h2A, 1'b0, 7'h51);
    n = 0;
    repeat (21000) @(negedge CLK) n += abort;
    chk("wdog_off", 8'h00, n[7:0]);
    ccc_xact_model_inst.close();
    wr(CCC_OFS_WDOG, 8'h02);
    ccc_xact_model_inst.xact(7'h2A, 1'b0, 7'h51);
    n = 0;
    while (abort !== 1'b1 && n < 25000) begin
      @(negedge CLK);
      n++;
    end
    chk("wdog_window", 8'h01, {7'h0, 1'(n >= 19990 && n <= 20010)});
    ccc_xact_model_inst.close();
    // Second reset with every register moved off its reset value
    wr(CCC_OFS_GEN_CFG1, 8'h80);
    ARST_N = 1'b0;
    repeat (2) @(negedge CLK);
    ARST_N = 1'b1;
    rd(CCC_OFS_GEN_CFG1, CCC_RST_GEN_CFG1);
    rd(CCC_OFS_WDOG, CCC_RST_WDOG);
    rd(CCC_OFS_SER_CTL1, CCC_RST_SER_CTL1);
    chk("crc_pull", 8'h03, {6'h0, crc, pull});
    chk("hold_glitch", 8'h1E, {1'b0, hold, glitch});
    tally_and_finish();
  end
endmodule
`default_nettype wire
